// [rtl/flp_intc.sv]
/*
 * Four-level interrupt priority and vectoring with a Wishbone classic
 * register slave and a sticky event interrupt.
 * Assumes request flags and core strobes come from logic on sys_clk.
 */
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "flp_params.svh"

module flp_intc
    import flp_pkg::*;
#(
    parameter int NUM_SRC = 15
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [9:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [NUM_SRC-1:0]   src_request,
    input  wire logic                 core_take,
    input  wire logic                 core_reti,
    output logic                      core_irq,
    output flp_vector_t               core_vector,
    output flp_level_t                core_level,
    output logic                      irq
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    flp_byte_t  priority_upper_bits_group_b;
    flp_byte_t  priority_lower_bits_group_b;
    flp_byte_t  priority_upper_bits_group_a;
    flp_byte_t  priority_lower_bits_group_a;
    flp_byte_t  enable_group_a;
    flp_byte_t  enable_group_b;
    logic [2:0] evt_status;
    logic [2:0] evt_enable;
    logic [3:0] in_service;

    // ****************************************************************
    // Decoding functions
    // ****************************************************************
    // Pick the bit belonging to a source out of group a and group b
    function automatic logic src_bit(input logic [3:0] idx,
                                     input flp_byte_t grp_a,
                                     input flp_byte_t grp_b);
        logic r;
        r = 1'b0;
        unique case (flp_src_t'(idx))
            FLP_SRC_X0:   r = grp_a[0];
            FLP_SRC_T0:   r = grp_a[1];
            FLP_SRC_X1:   r = grp_a[2];
            FLP_SRC_T1:   r = grp_a[3];
            FLP_SRC_UART: r = grp_a[4];
            FLP_SRC_TWS:  r = grp_a[5];
            FLP_SRC_ADC:  r = grp_a[6];
            FLP_SRC_T2:   r = grp_b[7];
            FLP_SRC_CAN:  r = grp_b[6];
            FLP_SRC_CM1:  r = grp_b[5];
            FLP_SRC_CM0:  r = grp_b[4];
            FLP_SRC_CT3:  r = grp_b[3];
            FLP_SRC_CT2:  r = grp_b[2];
            FLP_SRC_CT1:  r = grp_b[1];
            FLP_SRC_CT0:  r = grp_b[0];
            default:      r = 1'b0;
        endcase
        return r;
    endfunction : src_bit

    function automatic flp_vector_t src_vector(input logic [3:0] idx);
        flp_vector_t v;
        v = 16'h0000;
        unique case (flp_src_t'(idx))
            FLP_SRC_X0:   v = `FLP_VEC_X0;
            FLP_SRC_T0:   v = `FLP_VEC_T0;
            FLP_SRC_X1:   v = `FLP_VEC_X1;
            FLP_SRC_T1:   v = `FLP_VEC_T1;
            FLP_SRC_UART: v = `FLP_VEC_UART;
            FLP_SRC_TWS:  v = `FLP_VEC_TWS;
            FLP_SRC_CT0:  v = `FLP_VEC_CT0;
            FLP_SRC_CT1:  v = `FLP_VEC_CT1;
            FLP_SRC_CT2:  v = `FLP_VEC_CT2;
            FLP_SRC_CT3:  v = `FLP_VEC_CT3;
            FLP_SRC_ADC:  v = `FLP_VEC_ADC;
            FLP_SRC_CM0:  v = `FLP_VEC_CM0;
            FLP_SRC_CM1:  v = `FLP_VEC_CM1;
            FLP_SRC_CAN:  v = `FLP_VEC_CAN;
            FLP_SRC_T2:   v = `FLP_VEC_T2;
            default:      v = 16'h0000;
        endcase
        return v;
    endfunction : src_vector

    // Highest level currently marked in service
    function automatic flp_level_t top_of(input logic [3:0] mask);
        flp_level_t t;
        t = 2'd0;
        for (int k = 0; k < 4; k++) begin
            if (mask[k]) begin
                t = 2'(k);
            end
        end
        return t;
    endfunction : top_of

    // ****************************************************************
    // Per-source level and eligibility
    // ****************************************************************
    flp_level_t         src_level [NUM_SRC];
    logic [NUM_SRC-1:0] eligible;
    wire logic          global_en = enable_group_a[`FLP_BIT_GLOBAL_EN];

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            assign src_level[g] = {
                src_bit(4'(g), priority_upper_bits_group_a,
                        priority_upper_bits_group_b),
                src_bit(4'(g), priority_lower_bits_group_a,
                        priority_lower_bits_group_b)};
            assign eligible[g] = src_request[g] & global_en &
                src_bit(4'(g), enable_group_a, enable_group_b);
        end
    endgenerate

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    logic [3:0] best_idx;
    flp_level_t best_lvl;
    logic       best_valid;

    // Walk from the last source down so the earliest one wins a tie
    always_comb begin
        best_idx   = 4'd0;
        best_lvl   = 2'd0;
        best_valid = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!best_valid || src_level[i] >= best_lvl)) begin
                best_idx   = 4'(i);
                best_lvl   = src_level[i];
                best_valid = 1'b1;
            end
        end
    end

    wire flp_level_t svc_top  = top_of(in_service);
    wire logic       svc_any  = |in_service;
    wire logic       grant    = best_valid &&
                                (!svc_any || best_lvl > svc_top);
    wire logic       taken    = core_take & core_irq;
    wire logic       ret_ok   = core_reti & svc_any;
    wire logic       ret_bad  = core_reti & ~svc_any;

    // Returning frees the top level; a take in the same cycle stacks on
    wire logic [3:0] pop_mask = ret_ok ? (4'b0001 << svc_top) : 4'b0000;
    wire logic [3:0] push_mask = taken ? (4'b0001 << core_level) : 4'b0000;
    wire logic [3:0] next_in_service =
        (in_service & ~pop_mask) | push_mask;

    // ****************************************************************
    // Wishbone decode
    // ****************************************************************
    wire logic       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic [7:0] reg_idx   = wb_adr_i[9:2];
    wire logic       wr_lane   = bus_req & wb_we_i & wb_sel_i[0];
    wire flp_byte_t  wr_byte   = wb_dat_i[7:0];
    wire logic       wr_up_b   = wr_lane &&
                                 reg_idx == `FLP_IDX_PRIO_UPPER_B;
    wire logic       wr_lo_b   = wr_lane &&
                                 reg_idx == `FLP_IDX_PRIO_LOWER_B;
    wire logic       wr_up_a   = wr_lane && reg_idx == `FLP_IDX_PRIO_UPPER_A;
    wire logic       wr_lo_a   = wr_lane && reg_idx == `FLP_IDX_PRIO_LOWER_A;
    wire logic       wr_en_a   = wr_lane && reg_idx == `FLP_IDX_ENABLE_A;
    wire logic       wr_en_b   = wr_lane && reg_idx == `FLP_IDX_ENABLE_B;
    wire logic       wr_evt_c  = wr_lane && reg_idx == `FLP_IDX_EVT_CLEAR;
    wire logic       wr_evt_e  = wr_lane && reg_idx == `FLP_IDX_EVT_ENABLE;

    // Unmapped and write-only indices read as zero
    logic [7:0] rd_byte;
    always_comb begin
        unique case (reg_idx)
            `FLP_IDX_PRIO_UPPER_B: rd_byte = priority_upper_bits_group_b;
            `FLP_IDX_PRIO_LOWER_B: rd_byte = priority_lower_bits_group_b;
            `FLP_IDX_PRIO_UPPER_A: rd_byte = priority_upper_bits_group_a;
            `FLP_IDX_PRIO_LOWER_A: rd_byte = priority_lower_bits_group_a;
            `FLP_IDX_ENABLE_A:     rd_byte = enable_group_a;
            `FLP_IDX_ENABLE_B:     rd_byte = enable_group_b;
            `FLP_IDX_EVT_STATUS:   rd_byte = {5'h00, evt_status};
            `FLP_IDX_EVT_ENABLE:   rd_byte = {5'h00, evt_enable};
            `FLP_IDX_CORE_STATE:   rd_byte = {1'b0, core_irq, core_level,
                                              in_service};
            default:               rd_byte = 8'h00;
        endcase
    end

    // ****************************************************************
    // Event status
    // ****************************************************************
    wire logic [2:0] evt_set = {ret_bad, taken & svc_any, taken};
    // A set in the cycle of its clear wins, so no event is lost
    wire logic [2:0] next_evt_status =
        (evt_status & ~(wr_evt_c ? wr_byte[2:0] : 3'h0)) | evt_set;
    wire logic [2:0] next_evt_enable =
        wr_evt_e ? wr_byte[2:0] : evt_enable;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            priority_upper_bits_group_b <= `FLP_RST_BYTE;
            priority_lower_bits_group_b <= `FLP_RST_BYTE;
            priority_upper_bits_group_a <= `FLP_RST_BYTE;
            priority_lower_bits_group_a <= `FLP_RST_BYTE;
            enable_group_a              <= `FLP_RST_BYTE;
            enable_group_b              <= `FLP_RST_BYTE;
        end else begin
            if (wr_up_b) begin
                priority_upper_bits_group_b <= wr_byte;
            end
            if (wr_lo_b) begin
                priority_lower_bits_group_b <= wr_byte;
            end
            if (wr_up_a) begin
                priority_upper_bits_group_a <= wr_byte;
            end
            if (wr_lo_a) begin
                priority_lower_bits_group_a <= wr_byte;
            end
            if (wr_en_a) begin
                enable_group_a <= wr_byte;
            end
            if (wr_en_b) begin
                enable_group_b <= wr_byte;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Outputs are a registered snapshot; the core takes what it sees
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_irq    <= 1'b0;
            core_vector <= 16'h0000;
            core_level  <= 2'd0;
            in_service  <= 4'h0;
        end else begin
            core_irq    <= grant & ~taken;
            core_vector <= src_vector(best_idx);
            core_level  <= best_lvl;
            in_service  <= next_in_service;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_status <= `FLP_RST_EVT;
            evt_enable <= `FLP_RST_EVT;
            irq        <= 1'b0;
        end else begin
            evt_status <= next_evt_status;
            evt_enable <= next_evt_enable;
            irq        <= |(next_evt_status & next_evt_enable);
        end
    end

endmodule : flp_intc

// [rtl/flp_params.svh]
/*
 * Constants of the four-level interrupt priority block: register indices,
 * bit positions, reset values and vector addresses.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef FLP_PARAMS_SVH
`define FLP_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define FLP_IDX_PRIO_UPPER_B   8'hf7
`define FLP_IDX_PRIO_LOWER_B   8'hf8
`define FLP_IDX_PRIO_UPPER_A   8'hb7
`define FLP_IDX_PRIO_LOWER_A   8'hb8
`define FLP_IDX_ENABLE_A       8'ha8
`define FLP_IDX_ENABLE_B       8'he8
`define FLP_IDX_EVT_STATUS     8'hc0
`define FLP_IDX_EVT_CLEAR      8'hc1
`define FLP_IDX_EVT_ENABLE     8'hc2
`define FLP_IDX_CORE_STATE     8'hc3

// ****************************************************************
// Field positions
// ****************************************************************
`define FLP_BIT_GLOBAL_EN      3'd7
`define FLP_EVT_TAKEN          2'd0
`define FLP_EVT_PREEMPT        2'd1
`define FLP_EVT_BAD_RETURN     2'd2

// ****************************************************************
// Reset values
// ****************************************************************
`define FLP_RST_BYTE           8'h00
`define FLP_RST_EVT            3'h0

// ****************************************************************
// Vector addresses
// ****************************************************************
`define FLP_VEC_X0             16'h0003
`define FLP_VEC_T0             16'h000b
`define FLP_VEC_X1             16'h0013
`define FLP_VEC_T1             16'h001b
`define FLP_VEC_UART           16'h0023
`define FLP_VEC_TWS            16'h002b
`define FLP_VEC_CT0            16'h0033
`define FLP_VEC_CT1            16'h003b
`define FLP_VEC_CT2            16'h0043
`define FLP_VEC_CT3            16'h004b
`define FLP_VEC_ADC            16'h0053
`define FLP_VEC_CM0            16'h005b
`define FLP_VEC_CM1            16'h0063
`define FLP_VEC_CAN            16'h006b
`define FLP_VEC_T2             16'h0073

`endif

// [rtl/flp_pkg.sv]
/*
 * Types of the four-level interrupt priority block.
 * Assumes flp_params.svh on the include path.
 */
package flp_pkg;
    typedef logic [7:0]  flp_byte_t;
    typedef logic [1:0]  flp_level_t;
    typedef logic [15:0] flp_vector_t;

    // Sources numbered in fixed order within a level, first wins
    typedef enum logic [3:0] {
        FLP_SRC_X0, FLP_SRC_TWS, FLP_SRC_ADC, FLP_SRC_T0, FLP_SRC_CT0,
        FLP_SRC_CM0, FLP_SRC_X1, FLP_SRC_CT1, FLP_SRC_CM1, FLP_SRC_T1,
        FLP_SRC_CT2, FLP_SRC_CAN, FLP_SRC_UART, FLP_SRC_CT3, FLP_SRC_T2
    } flp_src_t;
endpackage : flp_pkg

// [verif/flp_core_model.sv]
/*
 * Core-side partner: takes an offered vector and returns from service.
 * Assumes bench strobes launched on sys_clk.
 */
`timescale 1ns/10ps
module flp_core_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       core_irq,
    input  wire logic       accept,
    input  wire logic       ret_req,
    input  wire logic [3:0] lag,
    output logic            core_take,
    output logic            core_reti
);
    logic [3:0] wait_cnt;
    logic       ret_prev;

    // Slow core: the offer must stand lag cycles before it is taken
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_take <= 1'b0;
            core_reti <= 1'b0;
            wait_cnt  <= 4'h0;
            ret_prev  <= 1'b0;
        end else begin
            core_take <= 1'b0;
            // One return per request edge, a held request must not unwind
            ret_prev  <= ret_req;
            core_reti <= ret_req & ~ret_prev;
            if (!core_irq || core_take) begin
                wait_cnt <= 4'h0;
            end else if (accept && wait_cnt >= lag) begin
                core_take <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule : flp_core_model

// [verif/flp_intc_props.sv]
/*
 * Port checker of flp_intc, bound into every instance.
 * Assumes flp_pkg types and one clock domain.
 */
`timescale 1ns/10ps
module flp_intc_props
    import flp_pkg::*;
#(
    parameter int NUM_SRC = 15
) (
    input wire logic               sys_clk,
    input wire logic               rst_b,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic [NUM_SRC-1:0] src_request,
    input wire logic               core_take,
    input wire logic               core_reti,
    input wire logic               core_irq,
    input wire flp_vector_t        core_vector,
    input wire flp_level_t         core_level,
    input wire logic               irq
);
    // Vector slot to source number, vectors sit eight bytes apart
    localparam int VMAP [15] = '{0, 3, 6, 9, 12, 1, 4, 7, 10, 13, 2, 5,
                                 8, 11, 14};
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_ack_has_cause: assert property ($rose(wb_ack_o)
        |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    a_read_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    a_byte_reg_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_take_drops_irq: assert property (core_take && core_irq |=> !core_irq)
        else $error("offer stands after take");
    a_irq_needs_req: assert property (src_request == '0 |=> !core_irq)
        else $error("offer without request");
    a_vector_source: assert property (core_irq |-> core_vector[2:0] == 3'h3
        && core_vector[15:7] == 9'h0 && core_vector[6:3] != 4'hf
        && ($past(src_request) & (15'h1 << VMAP[core_vector[6:3]])) != 0)
        else $error("vector of idle source");
    a_event_irq_cause: assert property ($rose(irq) |-> $past(core_take
        && core_irq || core_reti || wb_we_i && wb_stb_i))
        else $error("event irq without event");
endmodule : flp_intc_props

bind flp_intc flp_intc_props #(.NUM_SRC(NUM_SRC)) props_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .src_request(src_request), .irq(irq),
    .core_take(core_take), .core_reti(core_reti), .core_irq(core_irq),
    .core_vector(core_vector), .core_level(core_level));

// [verif/flp_intc_test.sv]
/*
 * Self-checking bench of flp_intc against a level and order model.
 * Assumes flp_core_model and the bound checker.
 */
`timescale 1ns/10ps
module flp_intc_test;
    import flp_pkg::*;
    logic        sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        core_take, core_reti, core_irq, irq, accept, ret_req;
    logic [3:0]  wb_sel_i, lag;
    logic [9:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [14:0] src_request;
    logic [7:0]  rv;
    flp_vector_t core_vector;
    flp_level_t  core_level;
    int          n_mismatch, total_checks, cyc_cnt, bi, bl, ea;
    int          lv[15], en[15];
    int          amap[7] = '{0, 3, 6, 9, 12, 1, 2};
    int          bmap[8] = '{4, 7, 10, 13, 5, 8, 11, 14};
    logic [15:0] vt[15] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b,
        16'h0033, 16'h005b, 16'h0013, 16'h003b, 16'h0063, 16'h001b,
        16'h0043, 16'h006b, 16'h0023, 16'h004b, 16'h0073};
    logic [7:0]  regs[6] = '{8'hb7, 8'hb8, 8'hf7, 8'hf8, 8'ha8, 8'he8};

    flp_intc dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .src_request(src_request), .irq(irq),
        .core_take(core_take), .core_reti(core_reti), .core_irq(core_irq),
        .core_vector(core_vector), .core_level(core_level));
    flp_core_model core_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .core_irq(core_irq),
        .accept(accept), .ret_req(ret_req), .lag(lag),
        .core_take(core_take), .core_reti(core_reti));

    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 8000) begin
            n_mismatch++;
            conclude();
        end
    end
    task conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Classic cycle; only the bench timeout ends the wait for ack
    task wb(input logic we, input logic [7:0] idx, d, input logic [3:0] s);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_sel_i <= s;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task rdchk(input logic [7:0] idx, input logic [31:0] m, exp);
        wb(1'b0, idx, 8'h00, 4'hf);
        chk("register", rd & m, exp);
    endtask : rdchk
    task setp(input logic [7:0] v[6]);
        for (int i = 0; i < 6; i++) wb(1'b1, regs[i], v[i], 4'hf);
        for (int i = 0; i < 8; i++) begin
            if (i < 7) lv[amap[i]] = {v[0][i], v[1][i]};
            if (i < 7) en[amap[i]] = v[4][i];
            lv[bmap[i]] = {v[2][i], v[3][i]};
            en[bmap[i]] = v[5][i];
        end
        ea = v[4][7];
    endtask : setp
    task offer(input logic [14:0] rq, input int top);
        src_request <= rq;
        repeat (3) @(posedge sys_clk);
        {bi, bl} = {-32'sd1, -32'sd1};
        for (int s = 0; s < 15; s++)
            if (rq[s] && en[s] != 0 && ea != 0 && lv[s] > bl) begin
                bi = s;
                bl = lv[s];
            end
        if (bl <= top) bi = -1;
        chk("offer", core_irq, bi >= 0);
        if (bi >= 0) chk("vector", core_vector, vt[bi]);
        if (bi >= 0) chk("level", core_level, bl[1:0]);
    endtask : offer
    // Drives the strobe itself, a copied argument would never reach it
    task pulse(input logic pick_ret);
        if (pick_ret) begin
            ret_req <= 1'b1;
        end else begin
            accept <= 1'b1;
        end
        repeat (8) @(posedge sys_clk);
        {accept, ret_req} <= 2'b00;
    endtask : pulse

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, accept, ret_req, rst_b} = 6'h0;
        {wb_sel_i, lag, wb_adr_i, wb_dat_i, src_request} = '0;
        void'($urandom(32'hcc69));
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        foreach (regs[i]) rdchk(regs[i], 32'hffffffff, 32'h0);
        rdchk(8'hc3, 32'hffffffff, 32'h0);
        $display("test reset values done");
        rv = 8'($urandom);
        wb(1'b1, 8'hf7, rv, 4'hf);
        wb(1'b1, 8'hf7, ~rv, 4'he);
        wb(1'b1, 8'hf8, ~rv, 4'hf);
        wb(1'b1, 8'h10, rv, 4'hf);
        rdchk(8'hf7, 32'hffffffff, {24'h0, rv});
        rdchk(8'hf8, 32'hffffffff, {24'h0, ~rv});
        rdchk(8'h10, 32'hffffffff, 32'h0);
        $display("test register access done");
        setp('{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff});
        for (int s = 0; s < 15; s++) offer(15'h1 << s, -1);
        offer(15'h7fff, -1);
        for (int k = 0; k < 40; k++) begin
            setp('{8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
                   8'($urandom) | 8'h80, 8'($urandom)});
            offer(15'($urandom), -1);
        end
        setp('{8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'hff});
        offer(15'h7fff, -1);
        $display("test order and vectors done");
        setp('{8'h00, 8'h01, 8'h80, 8'h81, 8'hff, 8'hff});
        wb(1'b1, 8'hc2, 8'h07, 4'hf);
        lag <= 4'($urandom_range(3));
        offer(15'h0010, -1);
        pulse(1'b0);
        rdchk(8'hc3, 32'hf, 32'h2);
        offer(15'h0011, 1);
        offer(15'h4011, 1);
        pulse(1'b0);
        src_request <= 15'h0;
        rdchk(8'hc3, 32'hf, 32'ha);
        wb(1'b1, 8'hc0, 8'h00, 4'hf);
        rdchk(8'hc0, 32'h7, 32'h3);
        chk("irq", irq, 1'b1);
        pulse(1'b1);
        rdchk(8'hc3, 32'hf, 32'h2);
        pulse(1'b1);
        rdchk(8'hc3, 32'hf, 32'h0);
        pulse(1'b1);
        rdchk(8'hc0, 32'h7, 32'h7);
        wb(1'b1, 8'hc2, 8'h00, 4'hf);
        rdchk(8'hc2, 32'hff, 32'h0);
        chk("irq", irq, 1'b0);
        wb(1'b1, 8'hc2, 8'h07, 4'hf);
        rdchk(8'hc2, 32'hff, 32'h7);
        chk("irq", irq, 1'b1);
        wb(1'b1, 8'hc1, 8'h07, 4'hf);
        rdchk(8'hc0, 32'h7, 32'h0);
        chk("irq", irq, 1'b0);
        $display("test preempt and events done");
        conclude();
    end
endmodule : flp_intc_test
